/* shared/dtc_defines.vh */
// Register offsets, field positions and reset values of the dual timer.
// Assumes byte addresses on a 32-bit Avalon-MM slave, data in bits 7:0.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// Byte offsets of the register words
`define DTC_ADDR_W          5
`define DTC_OFS_CTRL        5'h00
`define DTC_OFS_MODE        5'h04
`define DTC_OFS_T0_HI       5'h08
`define DTC_OFS_T0_LO       5'h0C
`define DTC_OFS_T1_HI       5'h10
`define DTC_OFS_T1_LO       5'h14
`define DTC_OFS_IRQ_STAT    5'h18
`define DTC_OFS_IRQ_MASK    5'h1C

// Event control register bit positions
`define DTC_CTRL_TF1        7
`define DTC_CTRL_TR1        6
`define DTC_CTRL_TF0        5
`define DTC_CTRL_TR0        4
`define DTC_CTRL_IE1        3
`define DTC_CTRL_IT1        2
`define DTC_CTRL_IE0        1
`define DTC_CTRL_IT0        0

// Mode register: per-timer nibble, timer 1 high, timer 0 low
`define DTC_MODE_GATE       3
`define DTC_MODE_CT         2
`define DTC_MODE_NIB        4

// Mode field encodings
`define DTC_M_PRESCALE      2'h0
`define DTC_M_FULL16        2'h1
`define DTC_M_RELOAD8       2'h2
`define DTC_M_STOP          2'h3

// Prescaler width (divide by 32)
`define DTC_PRE_W           5
`define DTC_PRE_MAX         5'h1F

// Event bit order in status, mask, ack and request vectors
`define DTC_EV_TF0          0
`define DTC_EV_IE0          1
`define DTC_EV_TF1          2
`define DTC_EV_IE1          3

// Reset values
`define DTC_RST_BYTE        8'h00
`define DTC_RST_EV          4'h0

`endif

/* logic/dtc_timer_block.v */
// Two 16-bit timer/counters with event control, mode register and irq.
// Assumes one 40 MHz clock; all pins are already synchronous to it.
//
// What this block does
// (R1) Overflow sets that timer's overflow flag
// (R2) Vector acknowledge clears timer overflow flag
// (R3) Run bit starts or stops each timer
// (R4) External interrupt 1 flags on both edges
// (R5) External flags set on edge, cleared on service
// (R6) Interrupt 1 type: edge or low level
// (R7) Interrupt 0 type: falling edge or low level
// (R8) Timer 0 split into readable/writable byte halves
// (R9) Timer 1 split into readable/writable byte halves
// (R10) Mode register holds timer 1 gate bit
// (R11) Mode register holds timer 0 gate bit
// (R12) Mode 00: 8-bit count after divide-by-32
// (R13) Mode 01: full 16-bit counter
// (R14) Mode 10: low byte reloads from high byte
// (R15) Two-bit mode field, 11 stops the timer
// (R16) Select bit: clock pulses or external events
// (R17) Gate: count only while interrupt pin high
// (R18) Flags raise interrupt requests to the processor
//
// Our own choices: the Avalon-MM register port and the register offsets.
`include "dtc_defines.vh"

module dtc_timer_block (
	input  wire                   sys_clk_i,       // System clock
	input  wire                   rst_i,           // Synchronous reset
	input  wire [`DTC_ADDR_W-1:0] address_i,       // Byte address
	input  wire                   read_i,          // Read request
	input  wire                   write_i,         // Write request
	input  wire [3:0]             byteenable_i,    // Byte lanes
	input  wire [31:0]            writedata_i,     // Write data
	output reg  [31:0]            readdata_o,      // Read data
	output reg                    waitrequest_o,   // Stall while high
	input  wire                   ext_irq_zero_i,  // External interrupt 0 pin
	input  wire                   ext_irq_one_i,   // External interrupt 1 pin
	input  wire                   count_zero_i,    // Timer 0 event input
	input  wire                   count_one_i,     // Timer 1 event input
	input  wire [3:0]             irq_ack_i,       // Vector acknowledge pulses
	output reg  [3:0]             irq_req_o,       // Requests to processor
	output reg                    irq_o            // Masked summary interrupt
);

	// Packed pin views, index equals timer or interrupt number
	wire [1:0] ext_pin;                  // Interrupt pins
	wire [1:0] cnt_pin;                  // Count inputs
	assign ext_pin = {ext_irq_one_i, ext_irq_zero_i};
	assign cnt_pin = {count_one_i, count_zero_i};

	// Software state
	reg  [1:0] timer_run;                // Run bits per timer
	wire [1:0] timer_ovf_flag;           // Overflow flags per timer
	wire [1:0] ext_irq_flag;             // External flags per pin
	reg  [1:0] ext_irq_type;             // 1 edge, 0 low level
	reg  [7:0] timer_operating_select;   // Mode register
	reg  [3:0] irq_status;               // Sticky event bits
	reg  [3:0] irq_mask;                 // Event enables

	// Previous pin samples for edge detection
	reg  [1:0] ext_prev;                 // Interrupt pins last cycle
	reg  [1:0] cnt_prev;                 // Count inputs last cycle

	// Bus decode
	// A write lands only on the edge where waitrequest is already low,
	// so each register sees exactly one update per accepted access.
	// Only byte lane 0 carries register data; other lanes are ignored,
	// and a write with lane 0 disabled changes nothing at all.
	// Unmapped offsets decode to no strobe and so are dropped quietly.
	wire       wr_go;                    // Write completing this edge
	wire       wr_lo;                    // Low byte lane enabled
	wire [7:0] wbyte;                    // Written byte
	assign wr_go = write_i & ~waitrequest_o;
	assign wr_lo = wr_go & byteenable_i[0];
	assign wbyte = writedata_i[7:0];

	wire       wr_ctrl;                  // Control register write
	wire       wr_mode;                  // Mode register write
	wire       wr_stat;                  // Status clear write
	wire       wr_mask;                  // Mask write
	wire [1:0] wr_hi;                    // High byte writes per timer
	wire [1:0] wr_lo_b;                  // Low byte writes per timer
	assign wr_ctrl    = wr_lo & (address_i == `DTC_OFS_CTRL);
	assign wr_mode    = wr_lo & (address_i == `DTC_OFS_MODE);
	assign wr_stat    = wr_lo & (address_i == `DTC_OFS_IRQ_STAT);
	assign wr_mask    = wr_lo & (address_i == `DTC_OFS_IRQ_MASK);
	assign wr_hi[0]   = wr_lo & (address_i == `DTC_OFS_T0_HI); // R8
	assign wr_lo_b[0] = wr_lo & (address_i == `DTC_OFS_T0_LO); // R8
	assign wr_hi[1]   = wr_lo & (address_i == `DTC_OFS_T1_HI); // R9
	assign wr_lo_b[1] = wr_lo & (address_i == `DTC_OFS_T1_LO); // R9

	// Edge and event terms
	wire [1:0] ext_fall;                 // Falling edge on interrupt pin
	wire [1:0] ext_any;                  // Any edge on interrupt pin
	wire [1:0] cnt_fall;                 // Falling edge on count input
	wire [1:0] ext_edge_sel;             // Edge that arms each flag
	wire [1:0] ext_set;                  // Flag set condition
	wire [1:0] ovf;                      // Overflow pulses per timer
	assign ext_fall = ext_prev & ~ext_pin;
	assign ext_any  = ext_prev ^ ext_pin;
	assign cnt_fall = cnt_prev & ~cnt_pin;
	assign ext_edge_sel[0] = ext_fall[0]; // R7
	assign ext_edge_sel[1] = ext_any[1];  // R4

	// Per-timer counters and per-pin flags
	// Each pass of the loop builds one timer and the flag of the pin
	// that shares its number, since that pin also gates the timer.
	// The flags live in their own per-pass registers and are joined
	// into the shared vectors by continuous assignment, so that every
	// bit has one driving process only.
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : tmr
			reg  [7:0] hi;               // Upper count byte / reload value
			reg  [7:0] lo;               // Lower count byte
			wire       gate;             // Gating control
			wire       ctsel;            // Counter/timer select
			wire [1:0] mode;             // Mode field
			wire       tick;             // One count step
			wire [8:0] lo_inc;           // Low byte plus one, with carry
			wire [8:0] hi_inc;           // High byte plus one, with carry
			wire [`DTC_PRE_W:0] pre_inc; // Prescaler plus one, with carry
			reg                 ovf_q;   // Overflow flag of this timer
			reg                 ext_q;   // External flag of this pin

			assign gate  = timer_operating_select[g*`DTC_MODE_NIB+`DTC_MODE_GATE];
			assign ctsel = timer_operating_select[g*`DTC_MODE_NIB+`DTC_MODE_CT];
			assign mode  = timer_operating_select[g*`DTC_MODE_NIB+1:g*`DTC_MODE_NIB];

			// Gated, selected count step; mode 11 never steps
			assign tick = timer_run[g]                   // R3
				& (~gate | ext_pin[g])                   // R10 R11 R17
				& (ctsel ? cnt_fall[g] : 1'b1)           // R16
				& (mode != `DTC_M_STOP);                 // R15

			assign lo_inc  = {1'b0, lo} + 9'h001;
			assign hi_inc  = {1'b0, hi} + 9'h001;
			assign pre_inc = {1'b0, lo[`DTC_PRE_W-1:0]} + 6'h01;

			// Overflow point per mode
			assign ovf[g] = tick & (
				(mode == `DTC_M_PRESCALE) ? (pre_inc[`DTC_PRE_W] & hi_inc[8]) :
				(mode == `DTC_M_FULL16)   ? (lo_inc[8] & hi_inc[8]) :
				(mode == `DTC_M_RELOAD8)  ? lo_inc[8] : 1'b0);

			// High byte: bus write wins over counting
			always @(posedge sys_clk_i)
			begin
				if (rst_i)
					hi <= `DTC_RST_BYTE;
				else if (wr_hi[g])
					hi <= wbyte;                                 // R8 R9
				else if (tick && mode == `DTC_M_PRESCALE && pre_inc[`DTC_PRE_W])
					hi <= hi_inc[7:0];                           // R12
				else if (tick && mode == `DTC_M_FULL16 && lo_inc[8])
					hi <= hi_inc[7:0];                           // R13
			end

			// Low byte: prescaler, low half, or reloading counter
			always @(posedge sys_clk_i)
			begin
				if (rst_i)
					lo <= `DTC_RST_BYTE;
				else if (wr_lo_b[g])
					lo <= wbyte;                                 // R8 R9
				else if (tick)
				begin
					case (mode)
						`DTC_M_PRESCALE:
							// Only the five prescaler bits move
							lo <= {lo[7:`DTC_PRE_W], pre_inc[`DTC_PRE_W-1:0]}; // R12
						`DTC_M_FULL16:
							lo <= lo_inc[7:0];                   // R13
						`DTC_M_RELOAD8:
							// Reload from the high byte on rollover
							lo <= lo_inc[8] ? hi : lo_inc[7:0];  // R14
						default:
							lo <= lo;                            // R15
					endcase
				end
			end

			// Overflow flag: hardware set wins over ack and writes
			// An overflow in the same cycle as an acknowledge keeps the
			// flag up, so a second overflow is never lost to the service
			// of the first one.
			always @(posedge sys_clk_i)
			begin
				if (rst_i)
					ovf_q <= 1'b0;
				else if (ovf[g])
					ovf_q <= 1'b1;                               // R1
				else if (irq_ack_i[g*2])
					ovf_q <= 1'b0;                               // R2
				else if (wr_ctrl)
					ovf_q <= wbyte[`DTC_CTRL_TF0 + g*2];
			end

			// Flag bit into the shared vector
			assign timer_ovf_flag[g] = ovf_q;

			// External flag: edge mode latches, level mode follows pin low
			assign ext_set[g] = ext_irq_type[g] ? ext_edge_sel[g] : ~ext_pin[g];

			// In level mode the flag simply mirrors a low pin, so an
			// acknowledge cannot clear it while the pin stays low; the
			// source must release the line to drop the request.
			always @(posedge sys_clk_i)
			begin
				if (rst_i)
					ext_q <= 1'b0;
				else if (ext_set[g])
					ext_q <= 1'b1;                               // R5 R6 R7
				else if (!ext_irq_type[g])
					ext_q <= 1'b0;                               // R6 R7
				else if (irq_ack_i[g*2+1])
					ext_q <= 1'b0;                               // R5
				else if (wr_ctrl)
					ext_q <= wbyte[`DTC_CTRL_IE0 + g*2];
			end

			// Flag bit into the shared vector
			assign ext_irq_flag[g] = ext_q;
		end
	endgenerate

	// Run and type bits plus mode register, software owned
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			timer_run              <= 2'h0;
			ext_irq_type           <= 2'h0;
			timer_operating_select <= `DTC_RST_BYTE;
		end
		else
		begin
			if (wr_ctrl)
			begin
				timer_run    <= {wbyte[`DTC_CTRL_TR1], wbyte[`DTC_CTRL_TR0]}; // R3
				ext_irq_type <= {wbyte[`DTC_CTRL_IT1], wbyte[`DTC_CTRL_IT0]}; // R6 R7
			end
			if (wr_mode)
				timer_operating_select <= wbyte;          // R10 R11 R15
		end
	end

	// Pin history for edge detection
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			ext_prev <= 2'h3;
			cnt_prev <= 2'h3;
		end
		else
		begin
			ext_prev <= ext_pin;
			cnt_prev <= cnt_pin;
		end
	end

	// Event pulses in status order
	wire [3:0] ev;                       // Events this cycle
	assign ev[`DTC_EV_TF0] = ovf[0];
	assign ev[`DTC_EV_IE0] = ext_set[0];
	assign ev[`DTC_EV_TF1] = ovf[1];
	assign ev[`DTC_EV_IE1] = ext_set[1];

	// Sticky status, write one to clear, set wins
	// The event term is ORed in after the clear, so an event arriving
	// in the very cycle software clears its bit leaves the bit set.
	// Level-mode pins raise their event bit on every cycle held low.
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
			irq_status <= `DTC_RST_EV;
		else if (wr_stat)
			irq_status <= (irq_status & ~wbyte[3:0]) | ev;
		else
			irq_status <= irq_status | ev;
	end

	// Mask register
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
			irq_mask <= `DTC_RST_EV;
		else if (wr_mask)
			irq_mask <= wbyte[3:0];
	end

	// Interrupt outputs from flops
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			irq_req_o <= `DTC_RST_EV;
			irq_o     <= 1'b0;
		end
		else
		begin
			// Per-source requests follow the flags
			irq_req_o[`DTC_EV_TF0] <= timer_ovf_flag[0]; // R18
			irq_req_o[`DTC_EV_IE0] <= ext_irq_flag[0];   // R18
			irq_req_o[`DTC_EV_TF1] <= timer_ovf_flag[1]; // R18
			irq_req_o[`DTC_EV_IE1] <= ext_irq_flag[1];   // R18
			irq_o <= |(irq_status & irq_mask);
		end
	end

	// Assembled event control byte
	wire [7:0] ctrl_view;                // Control register read value
	assign ctrl_view = {timer_ovf_flag[1], timer_run[1],
		timer_ovf_flag[0], timer_run[0],
		ext_irq_flag[1], ext_irq_type[1],
		ext_irq_flag[0], ext_irq_type[0]};

	// Read mux, unmapped addresses read zero
	// Counter bytes are read live; a 16-bit value read as two bytes
	// can tear if the low byte carries between the two accesses, so
	// software should stop the timer or re-read the high byte.
	reg  [7:0] rd_byte;                  // Selected register
	always @*
	begin
		case (address_i)
			`DTC_OFS_CTRL:     rd_byte = ctrl_view;
			`DTC_OFS_MODE:     rd_byte = timer_operating_select;
			`DTC_OFS_T0_HI:    rd_byte = tmr[0].hi;     // R8
			`DTC_OFS_T0_LO:    rd_byte = tmr[0].lo;     // R8
			`DTC_OFS_T1_HI:    rd_byte = tmr[1].hi;     // R9
			`DTC_OFS_T1_LO:    rd_byte = tmr[1].lo;     // R9
			`DTC_OFS_IRQ_STAT: rd_byte = {4'h0, irq_status};
			`DTC_OFS_IRQ_MASK: rd_byte = {4'h0, irq_mask};
			default:           rd_byte = 8'h00;
		endcase
	end

	// Avalon handshake: one wait state, then one ready cycle
	// waitrequest rests high, drops for one cycle after a request is
	// seen, then rises again; read data is captured in the wait cycle
	// and stands at the edge where the master samples waitrequest low.
	// Back-to-back accesses therefore take two edges each.
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			waitrequest_o <= 1'b1;
			readdata_o    <= 32'h00000000;
		end
		else if ((read_i | write_i) && waitrequest_o)
		begin
			// Accept on the next edge
			waitrequest_o <= 1'b0;
			readdata_o    <= {24'h000000, rd_byte};
		end
		else
			waitrequest_o <= 1'b1;
	end

endmodule

/* verification/dtc_timer_checker.sv */
// Concurrent checks on the dual timer's top-level ports.
// Assumes one clock domain and the synchronous active-high reset.
`include "dtc_defines.vh"
module dtc_timer_checker (
	input wire                   sys_clk_i,
	input wire                   rst_i,
	input wire [`DTC_ADDR_W-1:0] address_i,
	input wire                   read_i,
	input wire                   write_i,
	input wire [3:0]             byteenable_i,
	input wire [31:0]            writedata_i,
	input wire [31:0]            readdata_o,
	input wire                   waitrequest_o,
	input wire                   ext_irq_zero_i,
	input wire                   ext_irq_one_i,
	input wire [3:0]             irq_ack_i,
	input wire [3:0]             irq_req_o,
	input wire                   irq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	reg [7:0] ctl;  // Shadow of control byte
	reg [3:0] msk;  // Shadow of mask
	// Track accepted writes to control and mask
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			ctl <= 8'h00;
			msk <= 4'h0;
		end
		else if (write_i && !waitrequest_o && byteenable_i[0])
		begin
			if (address_i == `DTC_OFS_CTRL)
				ctl <= writedata_i[7:0];
			if (address_i == `DTC_OFS_IRQ_MASK)
				msk <= writedata_i[3:0];
		end
	end
	a_wait_one_cycle: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("wait state not restored");
	a_wait_answers: assert property ($rose(read_i || write_i) |=> !waitrequest_o)
		else $error("no answer after one wait state");
	a_read_upper_zero: assert property (read_i && !waitrequest_o |-> readdata_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_ie1_any_edge: assert property (ctl[2] && $changed(ext_irq_one_i) |-> ##[1:2] irq_req_o[3])
		else $error("pin one edge missed");
	a_ie0_falling: assert property (ctl[0] && $fell(ext_irq_zero_i) |-> ##[1:2] irq_req_o[1])
		else $error("pin zero falling edge missed");
	a_low_level: assert property (!ctl[0] && !ext_irq_zero_i [*3] |=> irq_req_o[1])
		else $error("low level not flagged");
	a_ack_clears: assert property (irq_ack_i[`DTC_EV_TF0] |=> ##1 !irq_req_o[0])
		else $error("acknowledge left overflow flag");
	a_masked_quiet: assert property (msk == 4'h0 && $past(msk) == 4'h0 && $past(msk, 2) == 4'h0 |-> !irq_o)
		else $error("interrupt with all masked");
	c_write: cover property (write_i && !waitrequest_o);
	c_irq: cover property ($rose(irq_o));
	c_ie1: cover property ($rose(irq_req_o[3]));
endmodule

/* verification/dtc_pin_model.sv */
// Far-side pins: external interrupt lines and count inputs.
// Assumes pulled-up lines, idle high; changes after rising edges.
module dtc_pin_model (
	input  wire sys_clk_i,
	output reg  irq_zero_o,
	output reg  irq_one_o,
	output reg  count_zero_o,
	output reg  count_one_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle levels at time zero
	initial
	begin
		irq_zero_o = 1'b1;
		irq_one_o = 1'b1;
		count_zero_o = 1'b1;
		count_one_o = 1'b1;
	end
	// Set both interrupt pin levels
	task pins(input z, input o);
	begin
		@(posedge sys_clk_i);
		irq_zero_o <= z;
		irq_one_o <= o;
	end
	endtask
	// Low pulses, one cycle low and one high each
	task pulse(input s, input integer n);
	begin
		repeat (n)
		begin
			@(posedge sys_clk_i);
			if (s)
				count_one_o <= 1'b0;
			else
				count_zero_o <= 1'b0;
			@(posedge sys_clk_i);
			count_one_o <= 1'b1;
			count_zero_o <= 1'b1;
		end
	end
	endtask
endmodule

/* verification/test_dtc_timer_block.sv */
// Self-checking bench for the dual timer block.
// Assumes the pin model and the checker bound below.
`include "dtc_defines.vh"
module test_dtc_timer_block;
	timeunit 1ns;
	timeprecision 1ps;
	reg         sys_clk_i, rst_i, read_i, write_i;
	reg  [4:0]  address_i;
	reg  [31:0] writedata_i;
	reg  [3:0]  irq_ack_i;
	reg  [3:0]  byteenable_i;
	wire [31:0] readdata_o;
	wire        waitrequest_o, irq_o, p0, p1, c0, c1;
	wire [3:0]  irq_req_o;
	reg  [7:0]  q, q2;
	integer     num_errors, total_checks, i;
	dtc_timer_block i_dtc_timer_block (.sys_clk_i, .rst_i, .address_i, .read_i, .write_i,
		.byteenable_i, .writedata_i, .readdata_o, .waitrequest_o,
		.ext_irq_zero_i(p0), .ext_irq_one_i(p1), .count_zero_i(c0), .count_one_i(c1),
		.irq_ack_i, .irq_req_o, .irq_o);
	dtc_pin_model i_dtc_pin_model (.sys_clk_i, .irq_zero_o(p0), .irq_one_o(p1),
		.count_zero_o(c0), .count_one_o(c1));
	// Clock at 25 ns
	initial
	begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = !sys_clk_i;
	end
	// One bus access, held until waitrequest is sampled low
	task bus(input w, input [4:0] a, input [7:0] d);
	begin
		@(posedge sys_clk_i);
		address_i <= a;
		writedata_i <= {24'h0, d};
		read_i <= !w;
		write_i <= w;
		do @(posedge sys_clk_i); while (waitrequest_o !== 1'b0);
		q = readdata_o[7:0];
		read_i <= 1'b0;
		write_i <= 1'b0;
	end
	endtask
	task chk(input [7:0] g, input [7:0] e);
	begin
		total_checks = total_checks + 1;
		if (g !== e)
		begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	end
	endtask
	task rdc(input [4:0] a, input [7:0] e);
	begin
		bus(1'b0, a, 8'h00);
		chk(q, e);
	end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task ack(input [3:0] m);
	begin
		@(posedge sys_clk_i);
		irq_ack_i <= m;
		@(posedge sys_clk_i);
		irq_ack_i <= 4'h0;
	end
	endtask
	// Reset values and byte registers
	task t_regs;
	begin
		for (i = 0; i < 8; i = i + 1)
			rdc({i[2:0], 2'b00}, 8'h00);
		for (i = 2; i < 6; i = i + 1)
			bus(1'b1, {i[2:0], 2'b00}, 8'hA0 + i[7:0]);
		for (i = 2; i < 6; i = i + 1)
			rdc({i[2:0], 2'b00}, 8'hA0 + i[7:0]);
		// Lane 0 disabled and unmapped offset: writes ignored
		byteenable_i <= 4'h0;
		bus(1'b1, `DTC_OFS_T0_HI, 8'h5A);
		byteenable_i <= 4'hF;
		rdc(`DTC_OFS_T0_HI, 8'hA2);
		bus(1'b1, 5'h02, 8'hA5);
		rdc(5'h02, 8'h00);
		$display("regs done");
	end
	endtask
	// Sixteen-bit overflow, run bit, acknowledge
	task t_full16;
	begin
		bus(1'b1, `DTC_OFS_MODE, 8'h01);
		bus(1'b1, `DTC_OFS_T0_HI, 8'hFF);
		bus(1'b1, `DTC_OFS_T0_LO, 8'hF0);
		bus(1'b1, `DTC_OFS_CTRL, 8'h10);
		wt(30);
		rdc(`DTC_OFS_CTRL, 8'h30);
		bus(1'b1, `DTC_OFS_CTRL, 8'h20);
		rdc(`DTC_OFS_T0_HI, 8'h00);
		bus(1'b0, `DTC_OFS_T0_LO, 8'h00);
		q2 = q;
		wt(8);
		rdc(`DTC_OFS_T0_LO, q2);
		chk({7'h0, irq_req_o[0]}, 8'h01);
		ack(4'h1);
		wt(2);
		rdc(`DTC_OFS_CTRL, 8'h00);
		$display("full16 done");
	end
	endtask
	// Auto-reload from the upper byte
	task t_reload;
	begin
		bus(1'b1, `DTC_OFS_MODE, 8'h20);
		bus(1'b1, `DTC_OFS_T1_HI, 8'hF0);
		bus(1'b1, `DTC_OFS_T1_LO, 8'hFE);
		bus(1'b1, `DTC_OFS_CTRL, 8'h40);
		wt(40);
		rdc(`DTC_OFS_CTRL, 8'hC0);
		bus(1'b1, `DTC_OFS_CTRL, 8'h80);
		ack(4'h4);
		wt(2);
		rdc(`DTC_OFS_CTRL, 8'h00);
		rdc(`DTC_OFS_T1_HI, 8'hF0);
		bus(1'b0, `DTC_OFS_T1_LO, 8'h00);
		chk({4'h0, q[7:4]}, 8'h0F);
		$display("reload done");
	end
	endtask
	// Prescaled event counting with gate
	task t_presc;
	begin
		bus(1'b1, `DTC_OFS_MODE, 8'h40);
		bus(1'b1, `DTC_OFS_T1_HI, 8'h00);
		bus(1'b1, `DTC_OFS_T1_LO, 8'h00);
		bus(1'b1, `DTC_OFS_CTRL, 8'h40);
		i_dtc_pin_model.pulse(1'b1, 32);
		rdc(`DTC_OFS_T1_HI, 8'h01);
		rdc(`DTC_OFS_T1_LO, 8'h00);
		bus(1'b1, `DTC_OFS_MODE, 8'hC0);
		i_dtc_pin_model.pins(1'b1, 1'b0);
		i_dtc_pin_model.pulse(1'b1, 32);
		rdc(`DTC_OFS_T1_HI, 8'h01);
		i_dtc_pin_model.pins(1'b1, 1'b1);
		i_dtc_pin_model.pulse(1'b1, 32);
		rdc(`DTC_OFS_T1_HI, 8'h02);
		bus(1'b1, `DTC_OFS_MODE, 8'h0B);
		bus(1'b1, `DTC_OFS_T0_LO, 8'h12);
		bus(1'b1, `DTC_OFS_CTRL, 8'h10);
		wt(20);
		rdc(`DTC_OFS_T0_LO, 8'h12);
		bus(1'b1, `DTC_OFS_MODE, 8'h05);
		bus(1'b1, `DTC_OFS_T0_HI, 8'h00);
		bus(1'b1, `DTC_OFS_T0_LO, 8'h00);
		bus(1'b1, `DTC_OFS_CTRL, 8'h10);
		i_dtc_pin_model.pulse(1'b0, 5);
		rdc(`DTC_OFS_T0_LO, 8'h05);
		bus(1'b1, `DTC_OFS_CTRL, 8'h00);
		$display("presc done");
	end
	endtask
	// External interrupt edges and levels
	task t_ext;
	begin
		bus(1'b1, `DTC_OFS_CTRL, 8'h05);
		i_dtc_pin_model.pins(1'b1, 1'b0);
		wt(3);
		rdc(`DTC_OFS_CTRL, 8'h0D);
		ack(4'h8);
		wt(2);
		rdc(`DTC_OFS_CTRL, 8'h05);
		i_dtc_pin_model.pins(1'b1, 1'b1);
		wt(3);
		rdc(`DTC_OFS_CTRL, 8'h0D);
		bus(1'b1, `DTC_OFS_CTRL, 8'h05);
		i_dtc_pin_model.pins(1'b0, 1'b1);
		wt(3);
		rdc(`DTC_OFS_CTRL, 8'h07);
		ack(4'h2);
		wt(2);
		rdc(`DTC_OFS_CTRL, 8'h05);
		bus(1'b1, `DTC_OFS_CTRL, 8'h05);
		i_dtc_pin_model.pins(1'b1, 1'b1);
		wt(3);
		rdc(`DTC_OFS_CTRL, 8'h05);
		bus(1'b1, `DTC_OFS_CTRL, 8'h00);
		i_dtc_pin_model.pins(1'b0, 1'b1);
		wt(3);
		rdc(`DTC_OFS_CTRL, 8'h02);
		i_dtc_pin_model.pins(1'b1, 1'b1);
		wt(3);
		rdc(`DTC_OFS_CTRL, 8'h00);
		$display("ext done");
	end
	endtask
	// Status, mask and summary interrupt
	task t_irq;
	begin
		bus(1'b1, `DTC_OFS_IRQ_STAT, 8'h0F);
		rdc(`DTC_OFS_IRQ_STAT, 8'h00);
		i_dtc_pin_model.pins(1'b0, 1'b1);
		wt(3);
		chk({7'h0, irq_o}, 8'h00);
		rdc(`DTC_OFS_IRQ_STAT, 8'h02);
		bus(1'b1, `DTC_OFS_IRQ_MASK, 8'h02);
		wt(2);
		chk({7'h0, irq_o}, 8'h01);
		i_dtc_pin_model.pins(1'b1, 1'b1);
		wt(2);
		bus(1'b1, `DTC_OFS_IRQ_STAT, 8'h02);
		wt(3);
		chk({7'h0, irq_o}, 8'h00);
		$display("irq done");
	end
	endtask
	// Reset in mid-run returns registers to zero
	task t_rst;
	begin
		bus(1'b1, `DTC_OFS_T1_HI, 8'h55);
		rst_i <= 1'b1;
		wt(2);
		rst_i <= 1'b0;
		rdc(`DTC_OFS_T1_HI, 8'h00);
		rdc(`DTC_OFS_MODE, 8'h00);
		$display("rst done");
	end
	endtask
	task summarize;
	begin
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	// Main sequence
	initial
	begin
		num_errors = 0;
		total_checks = 0;
		rst_i = 1'b1;
		read_i = 1'b0;
		write_i = 1'b0;
		address_i = 5'h00;
		writedata_i = 32'h0;
		irq_ack_i = 4'h0;
		byteenable_i = 4'hF;
		wt(4);
		rst_i <= 1'b0;
		t_regs;
		t_full16;
		t_reload;
		t_presc;
		t_ext;
		t_irq;
		t_rst;
		summarize;
	end
	// Watchdog
	initial
	begin
		wt(20000);
		num_errors = num_errors + 1;
		summarize;
	end
endmodule
bind dtc_timer_block dtc_timer_checker i_dtc_timer_checker (.sys_clk_i, .rst_i, .address_i,
	.read_i, .write_i, .byteenable_i, .writedata_i, .readdata_o, .waitrequest_o,
	.ext_irq_zero_i, .ext_irq_one_i, .irq_ack_i, .irq_req_o, .irq_o);
